/* File: hdl/prio_irq_consts.svh */
`ifndef PRIO_IRQ_CONSTS_SVH
`define PRIO_IRQ_CONSTS_SVH

// Source count and which sources form the peripheral group
`define SRC_COUNT      8
`define PERIPH_MASK    8'hf0

// Program counter width and the two vector addresses
`define PC_W           21
`define VEC_HIGH       21'h000008
`define VEC_LOW        21'h000018

// Register offsets on the plain register port
`define ADDR_W         4
`define OFS_INTCTL     4'h0
`define OFS_RSTCTL     4'h1
`define OFS_FLAGS      4'h2
`define OFS_ENABLES    4'h3
`define OFS_PRIOS      4'h4
`define OFS_STATUS     4'h5
`define OFS_MASK       4'h6
`define OFS_STATE      4'h7

// Field positions
`define BIT_HIGH_EN    7
`define BIT_LOW_EN     6
`define BIT_PRIO_MODE  7
`define EV_HIGH        0
`define EV_LOW         1
`define EV_RET         2

// Reset values
`define INTCTL_RESET   8'h00
`define RSTCTL_RESET   8'h00
`define STATUS_RESET   3'h0
`define MASK_RESET     3'h0

// Instruction boundaries waited after the request is first seen
`define LAT_WAITS      2
`define LAT_MIN        3
`define LAT_MAX        4

`endif

/* File: hdl/prio_irq_pkg.sv */
`include "prio_irq_consts.svh"

package prio_irq_pkg;

    // Register port request, one cycle per access
    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [`ADDR_W-1:0]   addr;
        logic [7:0]           wdata;
    } bus_req_t;

    // Redirect order to the core: stack push and program counter load
    typedef struct packed {
        logic                 load;
        logic [`PC_W-1:0]     addr;
        logic                 push;
        logic [`PC_W-1:0]     ret_addr;
    } vector_t;

    // Acceptance sequencer
    typedef enum logic [1:0] {
        st_idle,
        st_wait1,
        st_wait2
    } seq_state_t;

endpackage : prio_irq_pkg

/* File: hdl/source_slot.sv */
`timescale 1ns/1ns
`include "prio_irq_consts.svh"

module source_slot (
    // Clocking
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic ce,
    // Event and software access
    input  wire logic event_in,
    input  wire logic wr_flag,
    input  wire logic wr_enable,
    input  wire logic wr_prio,
    input  wire logic wbit_flag,
    input  wire logic wbit_enable,
    input  wire logic wbit_prio,
    // Stored bits
    output logic      flag_r,
    output logic      enable_r,
    output logic      prio_r
);
    logic flag_nxt;

    // Event sets the flag whatever the enables; set beats a write of zero
    assign flag_nxt = (wr_flag ? wbit_flag : flag_r) | event_in;

    // Per source flag, enable and priority
    always_ff @(posedge clock) begin
        if (reset) begin
            flag_r   <= 1'b0;
            enable_r <= 1'b0;
            prio_r   <= 1'b0;
        end else if (ce) begin
            flag_r <= flag_nxt;
            if (wr_enable) begin
                enable_r <= wbit_enable;
            end
            if (wr_prio) begin
                prio_r <= wbit_prio;
            end
        end
    end

    flag_sets_a: assert property (@(posedge clock) disable iff (reset)
        (ce && event_in) |=> flag_r)
        else $error("event did not set its flag");

endmodule : source_slot

/* File: hdl/prio_irq_ctrl.sv */
`timescale 1ns/1ns
`include "prio_irq_consts.svh"

// Overview of operation
// - High vector 000008h, low vector 000018h.
// - Enabled high request preempts low handler.
// - Each source: flag, enable, priority bit.
// - Priority mode only when reset-control bit 7.
// - Priority mode: bit7 high, bit6 low enable.
// - Flag, enable, global enable then vector.
// - Compatibility mode ignores priority bits.
// - Compat: bit6 peripherals, bit7 all sources.
// - Compat: every interrupt vectors to 000008h.
// - Acceptance clears the permitting global enable.
// - Acceptance pushes return address, loads vector.
// - Return instruction sets the enable again.
// - Pin events vector three to four cycles.
// - Flags set regardless of any enable.
// - Priority mode bit6 gates all low sources.
module prio_irq_ctrl (
    // Clocking
    input  wire logic                        clock,
    input  wire logic                        reset,
    input  wire logic                        ce,
    // Register port
    input  wire prio_irq_pkg::bus_req_t      bus,
    output logic [7:0]                       rdata,
    // Interrupt sources, one-cycle event pulses
    input  wire logic [`SRC_COUNT-1:0]       events,
    // Core sequencer
    input  wire logic                        instr_boundary,
    input  wire logic                        return_from_handler_instruction,
    input  wire logic [`PC_W-1:0]            return_address,
    output prio_irq_pkg::vector_t            vector,
    // Interrupt to a supervisor
    output logic                             irq
);
    import prio_irq_pkg::*;

    localparam int N = `SRC_COUNT;

    // Control registers
    logic [7:0]        intctl_r;
    logic [7:0]        rstctl_r;
    logic [7:0]        intctl_nxt;
    logic [2:0]        status_r;
    logic [2:0]        status_nxt;
    logic [2:0]        mask_r;
    logic              in_high_r;
    logic              in_low_r;
    logic              in_high_nxt;
    logic              in_low_nxt;
    seq_state_t        state_r;
    seq_state_t        state_nxt;
    vector_t           vector_r;
    vector_t           vector_nxt;
    logic [7:0]        rdata_r;
    logic [7:0]        rdata_nxt;

    // Per-source bits
    logic [N-1:0]      flags;
    logic [N-1:0]      enables;
    logic [N-1:0]      prios;

    // Decoded writes
    logic              wr_intctl;
    logic              wr_rstctl;
    logic              wr_flags;
    logic              wr_enables;
    logic              wr_prios;
    logic              wr_status;
    logic              wr_mask;

    // Request terms
    logic              prio_mode;
    logic              high_en;
    logic              low_en;
    logic [N-1:0]      armed;
    logic [N-1:0]      periph;
    logic              req_high;
    logic              req_low;
    logic              req_any;
    logic              issue;
    logic              accept_high;
    logic              accept_low;
    logic [2:0]        ev;

    // Address decode
    assign wr_intctl  = bus.wr && (bus.addr == `OFS_INTCTL);
    assign wr_rstctl  = bus.wr && (bus.addr == `OFS_RSTCTL);
    assign wr_flags   = bus.wr && (bus.addr == `OFS_FLAGS);
    assign wr_enables = bus.wr && (bus.addr == `OFS_ENABLES);
    assign wr_prios   = bus.wr && (bus.addr == `OFS_PRIOS);
    assign wr_status  = bus.wr && (bus.addr == `OFS_STATUS);
    assign wr_mask    = bus.wr && (bus.addr == `OFS_MASK);

    // One slot per source
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_slot
            source_slot u_slot (
                .clock       (clock),
                .reset       (reset),
                .ce          (ce),
                .event_in    (events[g]),
                .wr_flag     (wr_flags),
                .wr_enable   (wr_enables),
                .wr_prio     (wr_prios),
                .wbit_flag   (bus.wdata[g]),
                .wbit_enable (bus.wdata[g]),
                .wbit_prio   (bus.wdata[g]),
                .flag_r      (flags[g]),
                .enable_r    (enables[g]),
                .prio_r      (prios[g])
            );
        end
    endgenerate

    // Mode and global enables
    assign prio_mode = rstctl_r[`BIT_PRIO_MODE];
    assign high_en   = intctl_r[`BIT_HIGH_EN];
    assign low_en    = intctl_r[`BIT_LOW_EN];
    assign periph    = `PERIPH_MASK;
    assign armed     = flags & enables;

    // Priority mode: high level needs bit 7, low level bits 7 and 6.
    // Bit 7 gating low too keeps a low handler from being entered inside a high handler.
    // Compat mode: priority bits ignored, bit 6 gates the peripherals.
    assign req_high = prio_mode
        ? (high_en && |(armed & prios))
        : (high_en && |(armed & (~periph | {N{low_en}})));
    assign req_low  = prio_mode
        && high_en && low_en && |(armed & ~prios);
    assign req_any  = req_high || req_low;

    // Issue on the third boundary after the request is seen
    assign issue       = ce && instr_boundary && (state_r == st_wait2);
    assign accept_high = issue && req_high;
    assign accept_low  = issue && !req_high && req_low;

    // Latency sequencer, re-checks the request at each step
    always_comb begin
        state_nxt = state_r;
        if (instr_boundary) begin
            case (state_r)
                st_idle: begin
                    if (req_any) begin
                        state_nxt = st_wait1;
                    end
                end
                st_wait1: begin
                    state_nxt = req_any ? st_wait2 : st_idle;
                end
                st_wait2: begin
                    state_nxt = st_idle;
                end
                default: begin
                    state_nxt = st_idle;
                end
            endcase
        end
    end

    // Global enables: software write, then return sets, acceptance clears.
    // Acceptance wins over a same-cycle write so a handler is never doubled.
    always_comb begin
        intctl_nxt  = wr_intctl ? bus.wdata : intctl_r;
        in_high_nxt = in_high_r;
        in_low_nxt  = in_low_r;
        if (return_from_handler_instruction) begin
            if (!prio_mode || in_high_r || !in_low_r) begin
                intctl_nxt[`BIT_HIGH_EN] = 1'b1;
                in_high_nxt              = 1'b0;
            end else begin
                intctl_nxt[`BIT_LOW_EN] = 1'b1;
                in_low_nxt              = 1'b0;
            end
        end
        if (accept_high) begin
            intctl_nxt[`BIT_HIGH_EN] = 1'b0;
            in_high_nxt              = 1'b1;
        end
        if (accept_low) begin
            intctl_nxt[`BIT_LOW_EN] = 1'b0;
            in_low_nxt              = 1'b1;
        end
    end

    // Redirect order for the core
    always_comb begin
        vector_nxt          = '0;
        vector_nxt.ret_addr = return_address;
        if (accept_high || accept_low) begin
            vector_nxt.load = 1'b1;
            vector_nxt.push = 1'b1;
            vector_nxt.addr = accept_low ? `VEC_LOW : `VEC_HIGH;
        end
    end

    // Sticky status: set beats a same-cycle write-one clear
    assign ev         = {return_from_handler_instruction && ce, accept_low, accept_high};
    assign status_nxt = (wr_status ? (status_r & ~bus.wdata[2:0]) : status_r) | ev;
    assign irq        = |(status_r & mask_r);

    // Read mux, unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `OFS_INTCTL:  rdata_nxt = intctl_r;
                `OFS_RSTCTL:  rdata_nxt = rstctl_r;
                `OFS_FLAGS:   rdata_nxt = flags;
                `OFS_ENABLES: rdata_nxt = enables;
                `OFS_PRIOS:   rdata_nxt = prios;
                `OFS_STATUS:  rdata_nxt = {5'h00, status_r};
                `OFS_MASK:    rdata_nxt = {5'h00, mask_r};
                `OFS_STATE:   rdata_nxt = {4'h0, state_r, in_low_r, in_high_r};
                default:      rdata_nxt = 8'h00;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (reset) begin
            intctl_r  <= `INTCTL_RESET;
            rstctl_r  <= `RSTCTL_RESET;
            status_r  <= `STATUS_RESET;
            mask_r    <= `MASK_RESET;
            in_high_r <= 1'b0;
            in_low_r  <= 1'b0;
            state_r   <= st_idle;
            vector_r  <= '0;
            rdata_r   <= 8'h00;
        end else if (ce) begin
            intctl_r  <= intctl_nxt;
            status_r  <= status_nxt;
            in_high_r <= in_high_nxt;
            in_low_r  <= in_low_nxt;
            state_r   <= state_nxt;
            vector_r  <= vector_nxt;
            rdata_r   <= rdata_nxt;
            if (wr_rstctl) begin
                rstctl_r <= bus.wdata;
            end
            if (wr_mask) begin
                mask_r <= bus.wdata[2:0];
            end
        end
    end

    assign vector = vector_r;
    assign rdata  = rdata_r;

    // Helper: boundaries counted since the sequencer left idle
    logic [2:0] bnd_cnt_r;
    always_ff @(posedge clock) begin
        if (reset) begin
            bnd_cnt_r <= 3'h0;
        end else if (ce && instr_boundary) begin
            bnd_cnt_r <= (state_nxt == st_idle) ? 3'h0 : bnd_cnt_r + 3'h1;
        end
    end

    // Sequences for the acceptance steps
    sequence high_taken_s;
        accept_high ##1 (vector_r.load && vector_r.push);
    endsequence

    sequence low_taken_s;
        accept_low ##1 (vector_r.load && vector_r.push);
    endsequence

    high_vector_a: assert property (@(posedge clock) disable iff (reset)
        high_taken_s |-> (vector_r.addr == `VEC_HIGH))
        else $error("high acceptance did not load the high vector");

    low_vector_a: assert property (@(posedge clock) disable iff (reset)
        low_taken_s |-> (vector_r.addr == `VEC_LOW))
        else $error("low acceptance did not load the low vector");

    compat_single_vector_a: assert property (@(posedge clock)
        disable iff (reset)
        (issue && !prio_mode) |=> (!vector_r.load || vector_r.addr == `VEC_HIGH))
        else $error("compatibility mode used the low vector");

    high_first_a: assert property (@(posedge clock) disable iff (reset)
        (issue && req_high && req_low) |-> (accept_high && !accept_low))
        else $error("low request taken before a pending high request");

    enable_cleared_a: assert property (@(posedge clock) disable iff (reset)
        accept_high |=> (!intctl_r[`BIT_HIGH_EN] && in_high_r))
        else $error("acceptance left the high enable set");

    high_blocks_all_a: assert property (@(posedge clock)
        disable iff (reset)
        (in_high_r && !intctl_r[`BIT_HIGH_EN]) |-> !(accept_high || accept_low))
        else $error("interrupt taken inside a high handler");

    return_restores_a: assert property (@(posedge clock) disable iff (reset)
        (ce && return_from_handler_instruction && in_high_r && !accept_low
            && !accept_high) |=> intctl_r[`BIT_HIGH_EN])
        else $error("return did not set the high enable again");

    compat_no_low_a: assert property (@(posedge clock) disable iff (reset)
        !prio_mode |-> !req_low)
        else $error("low level request raised in compatibility mode");

    latency_count_a: assert property (@(posedge clock) disable iff (reset)
        issue |-> (bnd_cnt_r == 3'(`LAT_WAITS)))
        else $error("vector issued at the wrong boundary");

    // Low level steps; a low handler must stay open to high requests
    low_enable_cleared_a: assert property (@(posedge clock) disable iff (reset)
        accept_low |=> (!intctl_r[`BIT_LOW_EN] && in_low_r))
        else $error("acceptance left the low enable set");

    low_return_a: assert property (@(posedge clock)
        disable iff (reset)
        (ce && return_from_handler_instruction && prio_mode && in_low_r && !in_high_r
            && !accept_low) |=> intctl_r[`BIT_LOW_EN])
        else $error("return did not set the low enable again");

    high_preempts_a: assert property (@(posedge clock) disable iff (reset)
        (issue && in_low_r && req_high) |-> accept_high)
        else $error("high request did not preempt the low handler");

    redirect_pulse_a: assert property (@(posedge clock) disable iff (reset)
        (ce && vector_r.load) |=> !vector_r.load)
        else $error("redirect order stood for more than one cycle");

    push_with_load_a: assert property (@(posedge clock) disable iff (reset)
        vector_r.load |-> (vector_r.push
            && (vector_r.addr == `VEC_HIGH || vector_r.addr == `VEC_LOW)))
        else $error("redirect without a push or to a bad address");

    compat_periph_a: assert property (@(posedge clock)
        disable iff (reset)
        (issue && !prio_mode && !low_en && !(|(armed & ~periph))) |-> !accept_high)
        else $error("peripheral source taken with its group disabled");

endmodule : prio_irq_ctrl

/* File: testbench/core_model.sv */
`timescale 1ns/1ns
`include "prio_irq_consts.svh"

module core_model (
    // Clocking
    input  wire logic                  clock,
    input  wire logic                  reset,
    // Link to the controller
    input  wire prio_irq_pkg::vector_t vector,
    output logic                       instr_boundary,
    output logic                       return_from_handler_instruction,
    output logic [`PC_W-1:0]           return_address,
    // Bench control and observation
    input  wire logic                  ret_cmd,
    output logic [3:0]                 depth,
    output logic                       bad_vector
);
    import prio_irq_pkg::*;

    logic [1:0] phase_r;

    // Four clocks per instruction cycle, boundary on the last one
    assign instr_boundary = (phase_r == 2'h3);

    // Program counter, stack depth and vector sanity
    always_ff @(posedge clock) begin
        if (reset) begin
            phase_r <= 2'h0;
            return_address <= 21'h000100;
            depth <= 4'h0;
            bad_vector <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'h1;
            if (phase_r == 2'h3) begin
                return_address <= return_address + 21'h000002;
            end
            // Push and load travel together, only to a vector address
            if (vector.load !== vector.push) begin
                bad_vector <= 1'b1;
            end
            if (vector.load && vector.addr != `VEC_HIGH && vector.addr != `VEC_LOW) begin
                bad_vector <= 1'b1;
            end
            // Pushed address is the one shown at the accepting boundary
            if (vector.push && (vector.ret_addr + 21'h000002) != return_address) begin
                bad_vector <= 1'b1;
            end
            if (vector.push) begin
                depth <= depth + 4'h1;
            end else if (return_from_handler_instruction) begin
                depth <= depth - 4'h1;
            end
        end
    end

    // Return executes one cycle after the handler asks for it
    always_ff @(posedge clock) begin
        return_from_handler_instruction <= ret_cmd & ~reset;
    end
endmodule : core_model

/* File: testbench/two_level_interrupt_priority_controller_tb_top.sv */
`timescale 1ns/1ns
`include "prio_irq_consts.svh"

module two_level_interrupt_priority_controller_tb_top;
    import prio_irq_pkg::*;

    typedef struct {
        logic [7:0]       mode;
        logic [7:0]       ic;
        logic [7:0]       en;
        logic [7:0]       pr;
        logic [7:0]       ev;
        logic             hit;
        logic [`PC_W-1:0] addr;
        logic [7:0]       after;
    } row_t;

    logic              clock;
    logic              reset;
    logic              ce;
    bus_req_t          bus;
    logic [7:0]        rdata;
    logic [7:0]        events;
    logic              instr_boundary;
    logic              ret_pulse;
    logic [`PC_W-1:0]  ret_addr;
    vector_t           vector;
    logic              irq;
    logic              ret_cmd;
    logic [3:0]        depth;
    logic              bad_vector;
    int                num_errors;
    int                comparisons;
    int                cycles;
    logic              hit;
    int                n;
    logic [7:0]        v;
    row_t              rows [11];

    prio_irq_ctrl i_prio_irq_ctrl (.clock(clock), .reset(reset), .ce(ce), .bus(bus),
        .rdata(rdata), .events(events), .instr_boundary(instr_boundary),
        .return_from_handler_instruction(ret_pulse), .return_address(ret_addr),
        .vector(vector), .irq(irq));

    core_model i_core_model (.clock(clock), .reset(reset), .vector(vector),
        .instr_boundary(instr_boundary), .return_from_handler_instruction(ret_pulse),
        .return_address(ret_addr), .ret_cmd(ret_cmd), .depth(depth), .bad_vector(bad_vector));

    task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus <= '0;
        #1 d = rdata;
    endtask : rd

    // Pulse events, then watch for a redirect while counting boundaries
    task automatic fire(input logic [7:0] m, output logic h, output int nb);
        @(posedge clock);
        events <= m;
        @(posedge clock);
        events <= 8'h00;
        h = 1'b0;
        nb = 0;
        for (int i = 0; i < 24 && !h; i++) begin
            #1 h = (vector.load === 1'b1);
            if (!h) begin
                nb += int'(instr_boundary === 1'b1);
                @(posedge clock);
            end
        end
    endtask : fire

    // Handler tail: leave only the given flags, then return
    task automatic leave(input logic [7:0] keep);
        wr(`OFS_FLAGS, keep);
        @(posedge clock);
        ret_cmd <= 1'b1;
        @(posedge clock);
        ret_cmd <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : leave

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Hang guard, generous against roughly 600 expected cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        bus = '0;
        events = 8'h00;
        ret_cmd = 1'b0;
        rows = '{
            '{8'h00, 8'h80, 8'h01, 8'h00, 8'h01, 1'b1, `VEC_HIGH, 8'h00},
            '{8'h00, 8'h80, 8'h01, 8'h01, 8'h01, 1'b1, `VEC_HIGH, 8'h00},
            '{8'h00, 8'h80, 8'h10, 8'h00, 8'h10, 1'b0, 21'h0, 8'h80},
            '{8'h00, 8'hc0, 8'h10, 8'h10, 8'h10, 1'b1, `VEC_HIGH, 8'h40},
            '{8'h00, 8'h40, 8'h01, 8'h00, 8'h01, 1'b0, 21'h0, 8'h40},
            '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 1'b0, 21'h0, 8'h80},
            '{8'h80, 8'h80, 8'h01, 8'h01, 8'h01, 1'b1, `VEC_HIGH, 8'h00},
            '{8'h80, 8'hc0, 8'h01, 8'h00, 8'h01, 1'b1, `VEC_LOW, 8'h80},
            '{8'h80, 8'h80, 8'h10, 8'h00, 8'h10, 1'b0, 21'h0, 8'h80},
            '{8'h80, 8'h40, 8'h01, 8'h01, 8'h01, 1'b0, 21'h0, 8'h40},
            '{8'h80, 8'hc0, 8'h10, 8'h10, 8'h10, 1'b1, `VEC_HIGH, 8'h40}};
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        // Reset values, plus unmapped offsets 9 and 10
        foreach (rows[a]) begin
            rd(a == 8 ? 4'h9 : 4'(a), v);
            check("reset value", 21'h0, 21'(v));
        end
        $display("test reset done");
        // Ordinary cases: mode, enables and priorities against the vector
        foreach (rows[k]) begin
            wr(`OFS_RSTCTL, rows[k].mode);
            wr(`OFS_PRIOS, rows[k].pr);
            wr(`OFS_ENABLES, rows[k].en);
            wr(`OFS_INTCTL, rows[k].ic);
            fire(rows[k].ev, hit, n);
            check("load", 21'(rows[k].hit), 21'(hit));
            if (hit) begin
                check("vector", rows[k].addr, vector.addr);
                check("latency", 21'h1, 21'(n >= 3 && n <= 4));
            end
            rd(`OFS_FLAGS, v);
            check("flags", 21'(rows[k].ev), 21'(v));
            rd(`OFS_INTCTL, v);
            check("intctl accepted", 21'(rows[k].after), 21'(v));
            if (hit) begin
                leave(8'h00);
            end else begin
                wr(`OFS_FLAGS, 8'h00);
            end
            rd(`OFS_INTCTL, v);
            check("intctl returned", 21'(rows[k].ic), 21'(v));
            $display("test row %0d done", k);
        end
        // Both levels at once, status and mask, then preemption
        wr(`OFS_RSTCTL, 8'h80);
        wr(`OFS_PRIOS, 8'h01);
        wr(`OFS_ENABLES, 8'h03);
        wr(`OFS_STATUS, 8'hff);
        wr(`OFS_MASK, 8'h01);
        wr(`OFS_INTCTL, 8'hc0);
        rd(`OFS_STATUS, v);
        check("status cleared", 21'h0, 21'(v));
        fire(8'h03, hit, n);
        check("both load", 21'h1, 21'(hit));
        check("both vector", `VEC_HIGH, vector.addr);
        check("irq set", 21'h1, 21'(irq));
        wr(`OFS_MASK, 8'h00);
        #1 check("irq masked", 21'h0, 21'(irq));
        wr(`OFS_MASK, 8'h01);
        #1 check("irq unmasked", 21'h1, 21'(irq));
        wr(`OFS_STATUS, 8'h01);
        #1 check("irq cleared", 21'h0, 21'(irq));
        fire(8'h00, hit, n);
        check("blocked", 21'h0, 21'(hit));
        leave(8'h02);
        fire(8'h00, hit, n);
        check("low after return", `VEC_LOW, hit ? vector.addr : 21'h0);
        fire(8'h01, hit, n);
        check("preempt", `VEC_HIGH, hit ? vector.addr : 21'h0);
        @(posedge clock);
        #1 check("stack depth", 21'h2, 21'(depth));
        leave(8'h00);
        leave(8'h00);
        rd(`OFS_INTCTL, v);
        check("intctl restored", 21'hc0, 21'(v));
        check("stack empty", 21'h0, 21'(depth));
        check("vector sane", 21'h0, 21'(bad_vector));
        $display("test levels done");
        // Clock enable low: a write must not land
        @(posedge clock);
        ce <= 1'b0;
        wr(`OFS_MASK, 8'h00);
        ce <= 1'b1;
        rd(`OFS_MASK, v);
        check("mask frozen", 21'h1, 21'(v));
        $display("test freeze done");
        // Reset again in mid-run: mode and enables back to cleared
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rd(`OFS_INTCTL, v);
        check("intctl after reset", 21'h0, 21'(v));
        rd(`OFS_RSTCTL, v);
        check("rstctl after reset", 21'h0, 21'(v));
        check("irq after reset", 21'h0, 21'(irq));
        $display("test reset again done");
        conclude();
    end
endmodule : two_level_interrupt_priority_controller_tb_top
